// File: core/pfc_pkg.sv
// package: widths, field codes and fifo sizing for the progressive to field converter
package pfc_pkg;
    localparam int          PFC_PIX_W     = 24;
    localparam int          PFC_DIM_W     = 16;
    localparam int          PFC_FIFO_D    = 16;
    // fifo word: field, vsync, hsync, pixel
    localparam int          PFC_WORD_W    = PFC_PIX_W + 3;
    localparam int          PFC_HS_BIT    = PFC_PIX_W;
    localparam int          PFC_VS_BIT    = PFC_PIX_W + 1;
    localparam int          PFC_FLD_BIT   = PFC_PIX_W + 2;
    localparam logic        PFC_FIELD_ODD = 1'b0;
    localparam logic        PFC_FIELD_EVN = 1'b1;
    localparam logic [15:0] PFC_CNT_RST   = 16'h0000;
    localparam logic [15:0] PFC_CNT_ONE   = 16'h0001;
endpackage

// File: core/pfc_if.sv
// interface: video stream link between source/sink ends and the converter
interface pfc_if;
    import pfc_pkg::*;
    logic [PFC_PIX_W-1:0] in_pix;
    logic                 in_vsync;
    logic                 in_hsync;
    logic                 in_valid;
    logic                 in_ready;
    logic [PFC_PIX_W-1:0] out_pix;
    logic                 out_field;
    logic                 out_vsync;
    logic                 out_hsync;
    logic                 out_valid;
    logic                 out_ready;

    modport dev (
        input  in_pix, in_vsync, in_hsync, in_valid, out_ready,
        output in_ready, out_pix, out_field, out_vsync, out_hsync, out_valid
    );
    modport host (
        output in_pix, in_vsync, in_hsync, in_valid, out_ready,
        input  in_ready, out_pix, out_field, out_vsync, out_hsync, out_valid
    );
endinterface

// File: core/pfc_fifo.sv
// module: flip-flop fifo with valid/ready on both sides
module pfc_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // fill side
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    // drain side
    output logic      [WIDTH-1:0] rd_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             room_q;
    wire              push = wr_valid && wr_ready;
    wire              pop  = rd_valid && rd_ready;

    // ready comes from a flop so the fill side sees no path through the count compare
    assign cnt_d    = (AW+1)'(cnt_q + push - pop);
    assign wr_ready = room_q;
    assign rd_valid = (cnt_q != '0);
    assign rd_data  = mem_q[rp_q];

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            room_q <= 1'b1;
        end else begin
            if (push) wp_q <= AW'(wp_q + 1'b1);
            if (pop) rp_q <= AW'(rp_q + 1'b1);
            cnt_q <= cnt_d;
            room_q <= (cnt_d != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) mem_q[wp_q] <= wr_data;
    end
endmodule

// File: core/pfc_dev.sv
// module: converter end, progressive frames in, interlaced fields out
// Functional notes
// - input moves when valid and ready high
// - output moves when valid and ready high
// - source marks frame and line starts
// - line start without frame: vsync low, hsync high
// - output syncs mark first field pixel
// - field flag odd low, even high, steady
// - field holds half lines, full width
// - frame size from two 16-bit inputs
// - one field out per frame in
// - 24-bit pixels pass unchanged
// - source holds data while ready low
// - sink ignores data when valid low
// - one output pixel per clock possible
// - fifo drains without further input
// - sink always ready lets source ignore ready
module pfc_dev
    import pfc_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // frame size
    input  wire logic [PFC_DIM_W-1:0] pixels_per_line,
    input  wire logic [PFC_DIM_W-1:0] lines_per_frame,
    // stream link
    pfc_if.dev                        lnk
);
    // ------------------------------------------------------------
    // input position tracking
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PFC_LN_IDLE,
        PFC_LN_KEEP,
        PFC_LN_SKIP
    } pfc_ln_st_t;

    pfc_ln_st_t            st_q;
    pfc_ln_st_t            st_d;
    logic [PFC_DIM_W-1:0]  px_q;
    logic [PFC_DIM_W-1:0]  ln_q;
    logic                  parity_q;
    logic                  first_q;
    logic                  fifo_rdy;
    logic [PFC_WORD_W-1:0] f_dout;
    logic                  f_val;
    logic                  f_rdy;

    // wraps at the counter width; a frame larger than the size inputs loses its excess
    function automatic logic [PFC_DIM_W-1:0] step(logic [PFC_DIM_W-1:0] v);
        return PFC_DIM_W'(v + PFC_CNT_ONE);
    endfunction

    // a line belongs to the field when its index parity matches and it lies inside the frame
    function automatic logic line_kept(
        logic [PFC_DIM_W-1:0] idx,
        logic                 par,
        logic [PFC_DIM_W-1:0] lim
    );
        return (idx[0] == par) && (idx < lim);
    endfunction

    // ------------------------------------------------------------
    // link decode
    // ------------------------------------------------------------
    assign lnk.in_ready = fifo_rdy;

    wire                 in_go    = lnk.in_valid && fifo_rdy;
    wire                 sof      = lnk.in_vsync;
    // a frame start is also a line start, even if the source left hsync low
    wire                 sol      = lnk.in_hsync || lnk.in_vsync;
    wire                 started  = (st_q != PFC_LN_IDLE);
    // the pixel that opens a new frame already belongs to the next field
    wire                 par_now  = (sof && started) ? ~parity_q : parity_q;
    wire [PFC_DIM_W-1:0] line_idx = sof ? PFC_CNT_RST : (sol ? step(ln_q) : ln_q);
    wire [PFC_DIM_W-1:0] px_idx   = sol ? PFC_CNT_RST : px_q;
    wire                 ln_take  = line_kept(line_idx, par_now, lines_per_frame);
    wire                 px_take  = (px_idx < pixels_per_line);

    // ------------------------------------------------------------
    // line keep decision
    // ------------------------------------------------------------
    // pixels seen before the first frame start after reset are dropped:
    // a field can only begin on a frame boundary
    always_comb begin
        case (st_q)
            PFC_LN_IDLE: begin
                st_d = sof ? (ln_take ? PFC_LN_KEEP : PFC_LN_SKIP) : PFC_LN_IDLE;
            end
            PFC_LN_KEEP,
            PFC_LN_SKIP: begin
                st_d = sol ? (ln_take ? PFC_LN_KEEP : PFC_LN_SKIP) : st_q;
            end
            default: begin
                st_d = PFC_LN_IDLE;
            end
        endcase
    end

    wire                  keep = (st_d == PFC_LN_KEEP) && px_take;
    wire                  mark = keep && (sof || first_q);

    // ------------------------------------------------------------
    // fifo fill word
    // ------------------------------------------------------------
    // a dropped line still advances counters; fifo only sees kept pixels
    wire                  push = in_go && keep;
    wire [PFC_WORD_W-1:0] word = {par_now, mark, mark, lnk.in_pix};

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q     <= PFC_LN_IDLE;
            px_q     <= PFC_CNT_RST;
            ln_q     <= PFC_CNT_RST;
            parity_q <= PFC_FIELD_ODD;
            first_q  <= 1'b0;
        end else if (in_go) begin
            st_q     <= st_d;
            ln_q     <= line_idx;
            px_q     <= step(px_idx);
            parity_q <= par_now;
            first_q  <= keep ? 1'b0 : (sof || first_q);
        end
    end

    // ------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------
    pfc_fifo #(
        .WIDTH (PFC_WORD_W),
        .DEPTH (PFC_FIFO_D)
    ) i_pfc_fifo (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .wr_data  (word),
        .wr_valid (push),
        .wr_ready (fifo_rdy),
        .rd_data  (f_dout),
        .rd_valid (f_val),
        .rd_ready (f_rdy)
    );

    // ------------------------------------------------------------
    // registered output stage
    // ------------------------------------------------------------
    logic [PFC_PIX_W-1:0] pix_q;
    logic                 fld_q;
    logic                 vs_q;
    logic                 hs_q;
    logic                 val_q;

    // skid-free stage: load whenever empty or being taken, so full rate holds
    assign f_rdy = !val_q || lnk.out_ready;
    wire load = f_val && f_rdy;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            val_q <= 1'b0;
            pix_q <= '0;
            fld_q <= PFC_FIELD_ODD;
            vs_q  <= 1'b0;
            hs_q  <= 1'b0;
        end else if (f_rdy) begin
            val_q <= load;
            pix_q <= f_dout[PFC_PIX_W-1:0];
            fld_q <= f_dout[PFC_FLD_BIT];
            vs_q  <= f_dout[PFC_VS_BIT];
            hs_q  <= f_dout[PFC_HS_BIT];
        end
    end

    assign lnk.out_pix   = pix_q;
    assign lnk.out_field = fld_q;
    assign lnk.out_vsync = vs_q;
    assign lnk.out_hsync = hs_q;
    assign lnk.out_valid = val_q;
endmodule

// File: core/pfc_host.sv
// module: source and sink end of the video stream link
module pfc_host
    import pfc_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // user source side
    input  wire logic [PFC_PIX_W-1:0] src_pix,
    input  wire logic                 src_vsync,
    input  wire logic                 src_hsync,
    input  wire logic                 src_valid,
    output logic                      src_ready,
    // user sink side
    output logic      [PFC_PIX_W-1:0] snk_pix,
    output logic                      snk_field,
    output logic                      snk_vsync,
    output logic                      snk_hsync,
    output logic                      snk_valid,
    input  wire logic                 snk_ready,
    // stream link
    pfc_if.host                       lnk
);
    // ------------------------------------------------------------
    // source: hold register, stays put while ready low
    // ------------------------------------------------------------
    logic [PFC_PIX_W-1:0] sp_q;
    logic                 sv_q;
    logic                 ss_q;
    logic                 sh_q;
    wire                  s_go = lnk.in_ready || !sv_q;
    assign src_ready = s_go;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sv_q <= 1'b0;
            sp_q <= '0;
            ss_q <= 1'b0;
            sh_q <= 1'b0;
        end else if (s_go) begin
            sv_q <= src_valid;
            sp_q <= src_pix;
            ss_q <= src_vsync;
            sh_q <= src_hsync | src_vsync;
        end
    end

    assign lnk.in_pix   = sp_q;
    assign lnk.in_vsync = ss_q;
    assign lnk.in_hsync = sh_q;
    assign lnk.in_valid = sv_q;

    // ------------------------------------------------------------
    // sink: capture only on valid and ready
    // ------------------------------------------------------------
    assign lnk.out_ready = snk_ready;
    wire   o_go = lnk.out_valid && snk_ready;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            snk_valid <= 1'b0;
            snk_pix   <= '0;
            snk_field <= PFC_FIELD_ODD;
            snk_vsync <= 1'b0;
            snk_hsync <= 1'b0;
        end else begin
            snk_valid <= o_go;
            if (o_go) begin
                snk_pix   <= lnk.out_pix;
                snk_field <= lnk.out_field;
                snk_vsync <= lnk.out_vsync;
                snk_hsync <= lnk.out_hsync;
            end
        end
    end
endmodule

// File: tb/pfc_chk.sv
// checker: assertions on the stream link between host and converter
module pfc_chk
    import pfc_pkg::*;
(
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 resetn,
    // frame size
    input wire logic [PFC_DIM_W-1:0] pixels_per_line,
    input wire logic [PFC_DIM_W-1:0] lines_per_frame,
    // stream link
    input wire logic [PFC_PIX_W-1:0] in_pix,
    input wire logic                 in_vsync,
    input wire logic                 in_hsync,
    input wire logic                 in_valid,
    input wire logic                 in_ready,
    input wire logic [PFC_PIX_W-1:0] out_pix,
    input wire logic                 out_field,
    input wire logic                 out_vsync,
    input wire logic                 out_hsync,
    input wire logic                 out_valid,
    input wire logic                 out_ready
);
    // -------
    // helpers
    // -------
    logic        seen_q;
    logic        fld_q;
    logic        fst_q;
    logic [31:0] cnt_q;
    wire         out_go = out_valid && out_ready;
    // odd line counts are not covered: the field length is taken as floor(lines/2)
    wire  [31:0] fld_px = {16'h0000, pixels_per_line} * {17'h0_0000, lines_per_frame[15:1]};
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            seen_q <= 1'b0;
            fld_q  <= 1'b0;
            fst_q  <= 1'b1;
            cnt_q  <= 32'h0000_0000;
        end else begin
            seen_q <= seen_q || out_go;
            fld_q  <= out_go ? out_field : fld_q;
            cnt_q  <= !out_go ? cnt_q : (out_vsync ? 32'h0000_0001 : cnt_q + 32'h0000_0001);
            fst_q  <= fst_q && !(in_valid && in_ready && in_vsync);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_in_sof;
        in_valid && in_ready && in_vsync && in_hsync;
    endsequence
    sequence s_out_sof;
        out_valid && out_vsync && out_hsync;
    endsequence
    // -------
    // rules
    // -------
    a_reset_idle: assert property (disable iff (1'b0) !resetn |=> !out_valid && !out_field)
        else $error("outputs not idle after reset");
    a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pix) && $stable(out_field))
        else $error("output changed while stalled");
    a_first_odd: assert property (out_go && !seen_q |-> s_out_sof ##0 out_field == PFC_FIELD_ODD)
        else $error("first field not odd or unsynced");
    a_field_steady: assert property (out_go && seen_q && !out_vsync |-> out_field == fld_q)
        else $error("field flag moved inside field");
    a_field_flip: assert property (out_go && seen_q && out_vsync |-> out_field != fld_q)
        else $error("field parity did not alternate");
    a_sync_pair: assert property (out_valid && out_vsync |-> out_hsync)
        else $error("vsync without hsync");
    a_field_len: assert property (out_go && seen_q && out_vsync |-> cnt_q == fld_px)
        else $error("field length wrong");
    a_sof_pass: assert property (fst_q ##0 s_in_sof |-> ##[1:4] s_out_sof)
        else $error("first field start not passed on");
    a_out_rate: assert property (out_go && !in_ready |=> out_valid)
        else $error("gap in output while buffer full");
endmodule

// File: tb/tb_pfc.sv
// testbench: host ends facing the converter, checked frame by frame
module tb_pfc
    import pfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PPL = 10;
    localparam int LPF = 6;
    logic                 sys_clk = 1'b0;
    logic                 resetn;
    logic [PFC_PIX_W-1:0] src_pix;
    logic                 src_vsync;
    logic                 src_hsync;
    logic                 src_valid;
    logic                 src_ready;
    logic [PFC_PIX_W-1:0] snk_pix;
    logic                 snk_field;
    logic                 snk_vsync;
    logic                 snk_hsync;
    logic                 snk_valid;
    logic                 snk_ready;
    logic [PFC_PIX_W+2:0] exp_q[$];
    int                   n_errors = 0;
    int                   num_checks = 0;
    int                   k;
    always #2.5 sys_clk = ~sys_clk;
    pfc_if i_pfc_if ();
    pfc_dev i_pfc_dev (.sys_clk(sys_clk), .resetn(resetn), .pixels_per_line(16'(PPL)),
        .lines_per_frame(16'(LPF)), .lnk(i_pfc_if));
    pfc_host i_pfc_host (.sys_clk(sys_clk), .resetn(resetn), .src_pix(src_pix), .src_vsync(src_vsync),
        .src_hsync(src_hsync), .src_valid(src_valid), .src_ready(src_ready), .snk_pix(snk_pix),
        .snk_field(snk_field), .snk_vsync(snk_vsync), .snk_hsync(snk_hsync), .snk_valid(snk_valid),
        .snk_ready(snk_ready), .lnk(i_pfc_if));
    pfc_chk i_pfc_chk (.sys_clk(sys_clk), .resetn(resetn), .pixels_per_line(16'(PPL)),
        .lines_per_frame(16'(LPF)), .in_pix(i_pfc_if.in_pix), .in_vsync(i_pfc_if.in_vsync),
        .in_hsync(i_pfc_if.in_hsync), .in_valid(i_pfc_if.in_valid), .in_ready(i_pfc_if.in_ready),
        .out_pix(i_pfc_if.out_pix), .out_field(i_pfc_if.out_field), .out_vsync(i_pfc_if.out_vsync),
        .out_hsync(i_pfc_if.out_hsync), .out_valid(i_pfc_if.out_valid), .out_ready(i_pfc_if.out_ready));
    task automatic check(string what, logic [PFC_PIX_W+2:0] seen, logic [PFC_PIX_W+2:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // presents one pixel and holds it until the host source register takes it
    task automatic send(logic [PFC_PIX_W-1:0] p, logic vs, logic hs);
        int n;
        src_pix = p;
        src_vsync = vs;
        src_hsync = hs;
        src_valid = 1'b1;
        for (n = 0; n < 2000; n++) begin
            #1;
            if (src_ready === 1'b1) break;
            @(negedge sys_clk);
        end
        if (n == 2000) begin
            n_errors++;
            end_of_test();
        end
        @(negedge sys_clk);
    endtask
    task automatic frame(logic fld, logic [7:0] fc);
        for (int l = 0; l < LPF; l++) begin
            for (int p = 0; p < PPL; p++) begin
                if (l[0] == fld) exp_q.push_back({fld, {2{l == int'(fld) && p == 0}}, fc, 8'(l), 8'(p)});
                send({fc, 8'(l), 8'(p)}, l == 0 && p == 0, p == 0);
            end
        end
        src_valid = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic drain();
        for (k = 0; k < 500 && exp_q.size() != 0; k++) @(negedge sys_clk);
        repeat (8) @(negedge sys_clk);
        check("drained", 27'(exp_q.size() == 0), 27'h000_0001);
    endtask
    always @(negedge sys_clk) begin
        if (snk_valid === 1'b1) begin
            if (exp_q.size() == 0) check("extra", 27'h000_0001, 27'h000_0000);
            else check("word", {snk_field, snk_vsync, snk_hsync, snk_pix}, exp_q.pop_front());
        end
    end
    initial begin
        resetn = 1'b0;
        src_pix = '0;
        src_vsync = 1'b0;
        src_hsync = 1'b0;
        src_valid = 1'b0;
        snk_ready = 1'b0;
        repeat (12) @(negedge sys_clk);
        resetn = 1'b1;
        fork
            begin
                frame(1'b0, 8'h01);
                frame(1'b1, 8'h02);
            end
            begin
                for (k = 0; k < 600 && src_ready !== 1'b0; k++) @(negedge sys_clk);
                check("full", 27'(src_ready), 27'h000_0000);
                for (k = 0; k < 400; k++) begin
                    snk_ready = (k % 3) != 0;
                    @(negedge sys_clk);
                end
                snk_ready = 1'b1;
            end
        join
        drain();
        // a second reset must bring parity back to odd
        resetn = 1'b0;
        @(negedge sys_clk);
        resetn = 1'b1;
        frame(1'b0, 8'h03);
        drain();
        end_of_test();
    end
endmodule
